// file: rtl/tws_pkg.sv
`default_nettype none

package tws_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets on the plain register port.
   localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 8'h9D;
   localparam logic [ADDR_W-1:0] OFS_OWN_ADDRESS    = 8'h9E;
   localparam logic [ADDR_W-1:0] OFS_DATA_BUFFER    = 8'h9F;

   // Field positions of the control and status register.
   localparam int unsigned BIT_INTERFACE_ENABLE = 7;
   localparam int unsigned BIT_EVENT_FLAG       = 6;
   localparam int unsigned BIT_GC_MATCHED       = 4;
   localparam int unsigned BIT_ACK_ENABLE       = 3;
   localparam int unsigned BIT_STATE_HI         = 2;

   // Field positions of the own-address register.
   localparam int unsigned BIT_OWN_ADDR_HI = 7;
   localparam int unsigned BIT_OWN_ADDR_LO = 1;
   localparam int unsigned BIT_GC_ENABLE   = 0;

   // Reset values.
   localparam logic [DATA_W-1:0] RST_CONTROL_STATUS = 8'h00;
   localparam logic [DATA_W-1:0] RST_OWN_ADDRESS    = 8'h00;
   localparam logic [DATA_W-1:0] RST_DATA_BUFFER    = 8'h00;

   // Personality select value that routes the shared port to this block.
   localparam logic [1:0] PERSONALITY_TWO_WIRE = 2'h2;

   // General call address.
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

   // Bit counting within one frame: eight data bits then the acknowledge.
   localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
   localparam logic [3:0] CNT_ACK_DONE  = 4'h9;

   // State codes shown to software.
   localparam logic [2:0] CODE_IDLE        = 3'h0;
   localparam logic [2:0] CODE_FIRST_FRAME = 3'h1;
   localparam logic [2:0] CODE_RECEIVE     = 3'h2;
   localparam logic [2:0] CODE_TRANSMIT    = 3'h3;
   localparam logic [2:0] CODE_TX_NACKED   = 3'h4;
   localparam logic [2:0] CODE_TX_STOPPED  = 3'h5;

   typedef enum logic [2:0]
   {
      TWS_IDLE,
      TWS_FIRST_FRAME,
      TWS_RECEIVE,
      TWS_TRANSMIT,
      TWS_TX_NACKED,
      TWS_TX_STOPPED
   } tws_state_e;

endpackage

`default_nettype wire

// file: rtl/tws_line_if.sv
`timescale 1ns/1ps
`default_nettype none

// Sampled bus lines and their conditions, passed from the line watcher.
interface tws_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   modport watcher
   (
      output scl,
      output sda,
      output scl_rise,
      output scl_fall,
      output start_seen,
      output stop_seen
   );

   modport user
   (
      input scl,
      input sda,
      input scl_rise,
      input scl_fall,
      input start_seen,
      input stop_seen
   );
endinterface

`default_nettype wire

// file: rtl/tws_line_watch.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchronisers on both lines, then edge and condition detection.
module tws_line_watch
(
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_scl,
   input  wire logic i_sda,
   tws_line_if.watcher line
);
   import tws_pkg::*;

   logic scl_meta_r;
   logic scl_sync_r;
   logic scl_last_r;
   logic sda_meta_r;
   logic sda_sync_r;
   logic sda_last_r;

   // Both lines idle high through the pull-up, so reset to one.
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         scl_meta_r <= 1'b1;
         scl_sync_r <= 1'b1;
         scl_last_r <= 1'b1;
         sda_meta_r <= 1'b1;
         sda_sync_r <= 1'b1;
         sda_last_r <= 1'b1;
      end
      else
      begin
         scl_meta_r <= i_scl;
         scl_sync_r <= scl_meta_r;
         scl_last_r <= scl_sync_r;
         sda_meta_r <= i_sda;
         sda_sync_r <= sda_meta_r;
         sda_last_r <= sda_sync_r;
      end
   end

   // Start and stop need the clock high across the data change.
   assign line.scl        = scl_sync_r;
   assign line.sda        = sda_sync_r;
   assign line.scl_rise   = scl_sync_r & ~scl_last_r;
   assign line.scl_fall   = ~scl_sync_r & scl_last_r;
   assign line.start_seen = scl_sync_r & scl_last_r & sda_last_r & ~sda_sync_r;
   assign line.stop_seen  = scl_sync_r & scl_last_r & ~sda_last_r & sda_sync_r;

endmodule // tws_line_watch

`default_nettype wire

// file: rtl/tws_slave_port.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Block works only while the personality select input holds binary 10.
// - Slave only: never makes start, stop or drives the clock line.
// - Control bit 7 enables the slave; resets to zero.
// - Event flag bit 6 set on match, each byte, restart and stop.
// - Bit 4 shows a general call match, then clears by itself.
// - Acknowledge enable bit 3 lets the slave accept master data.
// - Code 000 is idle; a stop always returns there.
// - Eighth bit of the first frame: one is read, zero is write.
// - Code 010 means receiving, code 011 means transmitting.
// - Master not-acknowledge while sending moves to code 100.
// - Acknowledge enable cleared while sending moves to code 101.
// - Address register bits 7 to 1 hold own address; resets to zero.
// - Address register bit 0 enables answering the general call.
// - Data register at 9F holds the byte received or to send.
// - On own address match, drive acknowledge low in ninth period.
// - Acknowledge enable cleared while receiving: no acknowledge, back to idle.
// - General call address zero selects a write into receive state.
// - In read direction the data register byte is sent unaided.
module tws_slave_port
(
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic [1:0]            i_port_personality_select,
   input  wire logic [tws_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [tws_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output var  logic [tws_pkg::DATA_W-1:0] o_rdata,
   input  wire logic                  i_scl,
   input  wire logic                  i_sda,
   output var  logic                  o_sda_o,
   output var  logic                  o_sda_oe
);
   import tws_pkg::*;

   tws_line_if line ();
   tws_state_e        state_r;
   tws_state_e        state_nxt;
   logic [3:0]        bit_cnt_r;
   logic [3:0]        bit_cnt_nxt;
   logic [7:0]        shift_r;
   logic [7:0]        shift_nxt;
   logic              read_dir_r;
   logic              read_dir_nxt;
   logic              master_nack_r;
   logic              master_nack_nxt;
   logic              sda_oe_r;
   logic              sda_oe_nxt;
   logic              enable_r;
   logic              event_flag_r;
   logic              gc_matched_r;
   logic              gc_matched_nxt;
   logic              ack_enable_r;
   logic [6:0]        own_addr_r;
   logic              gc_enable_r;
   logic [7:0]        data_r;
   logic [7:0]        rdata_r;
   logic              hw_event;
   logic              hw_data_load;
   logic [2:0]        state_code;

   tws_line_watch u_watch
   (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_scl     (i_scl),
      .i_sda     (i_sda),
      .line      (line)
   );

   // Register decode.
   wire sel_ctl  = (i_addr == OFS_CONTROL_STATUS);
   wire sel_own  = (i_addr == OFS_OWN_ADDRESS);
   wire sel_data = (i_addr == OFS_DATA_BUFFER);
   wire wr_ctl   = i_wr & sel_ctl;
   wire wr_own   = i_wr & sel_own;
   wire wr_data  = i_wr & sel_data;

   // The block is live only in two-wire personality with the enable set.
   wire active   = enable_r &
                   (i_port_personality_select == PERSONALITY_TWO_WIRE);

   // First-frame decisions, taken from the shifted byte.
   wire [6:0] frame_addr = shift_r[7:1];
   wire       frame_rw   = shift_r[0];
   wire       own_hit    = (frame_addr == own_addr_r);
   wire       gc_hit     = gc_enable_r &
                           (frame_addr == GENERAL_CALL_ADDR) &
                           ~frame_rw;
   wire       addr_hit   = own_hit | gc_hit;
   wire ack_slot_begin = line.scl_fall & (bit_cnt_r == CNT_BYTE_DONE);
   wire ack_slot_end   = line.scl_fall & (bit_cnt_r == CNT_ACK_DONE);
   wire in_frame       = (state_r != TWS_IDLE);
   wire mid_transfer   = in_frame & (state_r != TWS_FIRST_FRAME);

   always_comb
   begin
      state_nxt       = state_r;
      bit_cnt_nxt     = bit_cnt_r;
      shift_nxt       = shift_r;
      read_dir_nxt    = read_dir_r;
      master_nack_nxt = master_nack_r;
      sda_oe_nxt      = sda_oe_r;
      gc_matched_nxt  = gc_matched_r;
      hw_event        = 1'b0;
      hw_data_load    = 1'b0;
      if (!active)
      begin
         state_nxt   = TWS_IDLE;
         bit_cnt_nxt = 4'h0;
         sda_oe_nxt  = 1'b0;
      end
      else if (line.stop_seen)
      begin
         // A stop ends any transfer, whatever the state.
         state_nxt      = TWS_IDLE;
         bit_cnt_nxt    = 4'h0;
         sda_oe_nxt     = 1'b0;
         gc_matched_nxt = 1'b0;
         hw_event       = in_frame;
      end
      else if (line.start_seen)
      begin
         state_nxt      = TWS_FIRST_FRAME;
         bit_cnt_nxt    = 4'h0;
         sda_oe_nxt     = 1'b0;
         gc_matched_nxt = 1'b0;
         hw_event       = mid_transfer;
      end
      else if (in_frame)
      begin
         if (line.scl_rise)
         begin
            if ((bit_cnt_r < CNT_BYTE_DONE) && (state_r != TWS_TRANSMIT))
            begin
               shift_nxt = {shift_r[6:0], line.sda};
            end
            else if (bit_cnt_r == CNT_BYTE_DONE)
            begin
               master_nack_nxt = line.sda;
            end
            if (bit_cnt_r < CNT_ACK_DONE)
            begin
               bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
         end
         else if (ack_slot_begin)
         begin
            unique case (state_r)
               TWS_FIRST_FRAME:
               begin
                  if (addr_hit)
                  begin
                     sda_oe_nxt     = 1'b1;
                     read_dir_nxt   = frame_rw;
                     gc_matched_nxt = gc_hit & ~own_hit;
                     hw_event       = 1'b1;
                  end
                  else
                  begin
                     state_nxt   = TWS_IDLE;
                     bit_cnt_nxt = 4'h0;
                  end
               end
               TWS_RECEIVE:
               begin
                  hw_data_load = 1'b1;
                  hw_event     = 1'b1;
                  if (ack_enable_r)
                  begin
                     sda_oe_nxt = 1'b1;
                  end
                  else
                  begin
                     // Byte is kept, but no acknowledge and no more data.
                     state_nxt   = TWS_IDLE;
                     bit_cnt_nxt = 4'h0;
                  end
               end
               TWS_TRANSMIT:
               begin
                  sda_oe_nxt = 1'b0;
                  hw_event   = 1'b1;
               end
               default: sda_oe_nxt = 1'b0;
            endcase
         end
         else if (ack_slot_end)
         begin
            bit_cnt_nxt = 4'h0;
            sda_oe_nxt  = 1'b0;
            unique case (state_r)
               TWS_FIRST_FRAME:
               begin
                  if (read_dir_r)
                  begin
                     state_nxt  = TWS_TRANSMIT;
                     shift_nxt  = data_r;
                     sda_oe_nxt = ~data_r[7];
                  end
                  else
                  begin
                     state_nxt = TWS_RECEIVE;
                  end
               end
               TWS_TRANSMIT:
               begin
                  if (master_nack_r)
                  begin
                     state_nxt = TWS_TX_NACKED;
                  end
                  else if (!ack_enable_r)
                  begin
                     state_nxt = TWS_TX_STOPPED;
                  end
                  else
                  begin
                     shift_nxt  = data_r;
                     sda_oe_nxt = ~data_r[7];
                  end
               end
               default: state_nxt = state_r;
            endcase
         end
         else if (line.scl_fall & (state_r == TWS_TRANSMIT) &
                  (bit_cnt_r < CNT_BYTE_DONE))
         begin
            // Next data bit goes out while the clock is low.
            sda_oe_nxt = ~shift_r[3'h7 - bit_cnt_r[2:0]];
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         state_r       <= TWS_IDLE;
         bit_cnt_r     <= 4'h0;
         shift_r       <= 8'h00;
         read_dir_r    <= 1'b0;
         master_nack_r <= 1'b0;
         sda_oe_r      <= 1'b0;
         gc_matched_r  <= 1'b0;
      end
      else
      begin
         state_r       <= state_nxt;
         bit_cnt_r     <= bit_cnt_nxt;
         shift_r       <= shift_nxt;
         read_dir_r    <= read_dir_nxt;
         master_nack_r <= master_nack_nxt;
         sda_oe_r      <= sda_oe_nxt;
         gc_matched_r  <= gc_matched_nxt;
      end
   end

   // Software registers. A hardware event in the clearing cycle wins.
   wire flag_keep  = event_flag_r & ~(wr_ctl & ~i_wdata[BIT_EVENT_FLAG]);
   wire flag_nxt   = hw_event | flag_keep;
   // A received byte overwrites a software write in the same cycle.
   wire [7:0] data_nxt = hw_data_load ? shift_r :
                         (wr_data ? i_wdata : data_r);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         enable_r     <= RST_CONTROL_STATUS[BIT_INTERFACE_ENABLE];
         event_flag_r <= RST_CONTROL_STATUS[BIT_EVENT_FLAG];
         ack_enable_r <= RST_CONTROL_STATUS[BIT_ACK_ENABLE];
         own_addr_r   <= RST_OWN_ADDRESS[BIT_OWN_ADDR_HI:BIT_OWN_ADDR_LO];
         gc_enable_r  <= RST_OWN_ADDRESS[BIT_GC_ENABLE];
         data_r       <= RST_DATA_BUFFER;
      end
      else
      begin
         event_flag_r <= flag_nxt;
         data_r       <= data_nxt;
         if (wr_ctl)
         begin
            enable_r     <= i_wdata[BIT_INTERFACE_ENABLE];
            ack_enable_r <= i_wdata[BIT_ACK_ENABLE];
         end
         if (wr_own)
         begin
            own_addr_r  <= i_wdata[BIT_OWN_ADDR_HI:BIT_OWN_ADDR_LO];
            gc_enable_r <= i_wdata[BIT_GC_ENABLE];
         end
      end
   end

   always_comb
   begin
      unique case (state_r)
         TWS_IDLE:        state_code = CODE_IDLE;
         TWS_FIRST_FRAME: state_code = CODE_FIRST_FRAME;
         TWS_RECEIVE:     state_code = CODE_RECEIVE;
         TWS_TRANSMIT:    state_code = CODE_TRANSMIT;
         TWS_TX_NACKED:   state_code = CODE_TX_NACKED;
         TWS_TX_STOPPED:  state_code = CODE_TX_STOPPED;
         default:         state_code = CODE_IDLE;
      endcase
   end

   // Reserved bit 5 reads as zero.
   wire [7:0] ctl_view = {enable_r, event_flag_r, 1'b0, gc_matched_r,
                          ack_enable_r, state_code};
   wire [7:0] own_view = {own_addr_r, gc_enable_r};
   wire [7:0] read_mux = sel_ctl  ? ctl_view :
                         sel_own  ? own_view :
                         sel_data ? data_r   : 8'h00;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         rdata_r <= i_rd ? read_mux : 8'h00;
      end
   end

   assign o_rdata  = rdata_r;
   // Open drain: the line is only ever pulled low, the clock never driven.
   assign o_sda_o  = 1'b0;
   assign o_sda_oe = sda_oe_r;

endmodule // tws_slave_port

`default_nettype wire

// file: verification/tws_slave_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tws_slave_port_chk
(
   input wire logic                         i_clk,
   input wire logic                         i_sys_rst,
   input wire logic [1:0]                   i_port_personality_select,
   input wire logic [tws_pkg::ADDR_W-1:0]   i_addr,
   input wire logic [tws_pkg::DATA_W-1:0]   i_wdata,
   input wire logic                         i_wr,
   input wire logic                         i_rd,
   input wire logic [tws_pkg::DATA_W-1:0]   o_rdata,
   input wire logic                         i_scl,
   input wire logic                         i_sda,
   input wire logic                         o_sda_o,
   input wire logic                         o_sda_oe
);
   import tws_pkg::*;
   wire logic wr_ctl = i_wr && i_addr == OFS_CONTROL_STATUS;
   wire logic rd_ctl = i_rd && i_addr == OFS_CONTROL_STATUS;
   wire logic wr_own = i_wr && i_addr == OFS_OWN_ADDRESS;
   wire logic rd_own = i_rd && i_addr == OFS_OWN_ADDRESS;
   wire logic rd_bad = i_rd && (i_addr < OFS_CONTROL_STATUS
                       || i_addr > OFS_DATA_BUFFER);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   chk_sda_low_only: assert property (o_sda_o == 1'b0)
      else $error("data line driven high");
   // The data line may only move while the clock line is low.
   chk_sda_move_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data line changed while clock high");
   chk_ack_holds: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
      else $error("low drive ended too soon");
   chk_sel_release: assert property
      ((i_port_personality_select != PERSONALITY_TWO_WIRE)[*2] |=> !o_sda_oe)
      else $error("line driven with other personality");
   chk_off_release: assert property (wr_ctl && !i_wdata[7] |=> ##1 !o_sda_oe)
      else $error("line driven while disabled");
   chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside read slot");
   chk_unmapped_zero: assert property (rd_bad |=> o_rdata == '0)
      else $error("unmapped read not zero");
   chk_own_addr_back: assert property
      ($past(wr_own) && rd_own |=> o_rdata == $past(i_wdata, 2))
      else $error("own address readback wrong");
   chk_ctl_fields: assert property ($past(wr_ctl) && rd_ctl |=>
      o_rdata[7] == $past(i_wdata[7], 2) && !o_rdata[5]
      && o_rdata[3] == $past(i_wdata[3], 2))
      else $error("control readback wrong");
endmodule // tws_slave_port_chk

bind tws_slave_port tws_slave_port_chk chk_u
(
   .i_clk, .i_sys_rst, .i_port_personality_select, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_scl, .i_sda, .o_sda_o, .o_sda_oe
);

`default_nettype wire

// file: verification/tws_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master: clock line half period is six system cycles (48 ns period).
module tws_master_model
(
   input  wire logic i_clk,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_low
);
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Data changes mid low phase; the line is sampled at the end of high.
   task automatic bit_cyc(input logic b, output logic r);
      wt(3);
      o_sda_low <= ~b;
      wt(3);
      o_scl <= 1'b1;
      wt(6);
      r = i_sda;
      o_scl <= 1'b0;
   endtask
   task automatic start_cond();
      o_sda_low <= 1'b0;
      wt(3);
      o_scl <= 1'b1;
      wt(3);
      o_sda_low <= 1'b1;
      wt(3);
      o_scl <= 1'b0;
   endtask
   // The clock line stays high after a stop, standing still between frames.
   task automatic stop_cond();
      o_sda_low <= 1'b1;
      wt(3);
      o_scl <= 1'b1;
      wt(3);
      o_sda_low <= 1'b0;
      wt(6);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], r);
      bit_cyc(1'b1, ack);
      // Hold the clock low until the slave has left the acknowledge slot.
      wt(4);
   endtask
   task automatic fetch(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
      bit_cyc(nack, r);
      wt(4);
   endtask
endmodule // tws_master_model

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   import tws_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] sel = PERSONALITY_TWO_WIRE;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       scl, m_low, sda_o, sda_oe, a;
   logic [7:0] d;
   wire logic  sda_w = ~(m_low | (sda_oe & ~sda_o));
   int         error_cnt = 0;
   int         checks = 0;
   int         cyc = 0;
   localparam logic [7:0] CTL = OFS_CONTROL_STATUS;

   always #2 clk = ~clk;

   tws_slave_port dut_u
   (
      .i_clk(clk), .i_sys_rst(rst), .i_port_personality_select(sel),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_scl(scl), .i_sda(sda_w), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe)
   );
   tws_master_model mst_u
   (
      .i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(m_low)
   );

   task automatic summarize();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask
   // Strobes change at the edge. A write returns at the edge that takes it,
   // so two writes in a row need no edge between them.
   task automatic wr_reg(input logic [7:0] ad, dt);
      addr <= ad;
      wdata <= dt;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] ad, e, input string n);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(n, rdata, e);
      @(posedge clk);
   endtask

   task automatic t_regs();
      rd_chk(CTL, RST_CONTROL_STATUS, "ctl reset");
      rd_chk(OFS_OWN_ADDRESS, RST_OWN_ADDRESS, "addr reset");
      rd_chk(OFS_DATA_BUFFER, RST_DATA_BUFFER, "data reset");
      wr_reg(8'h9C, 8'hFF);
      rd_chk(8'h9C, 8'h00, "unmapped");
      wr_reg(OFS_OWN_ADDRESS, 8'h5B);
      rd_chk(OFS_OWN_ADDRESS, 8'h5B, "addr rw");
      wr_reg(OFS_DATA_BUFFER, 8'hC3);
      rd_chk(OFS_DATA_BUFFER, 8'hC3, "data rw");
      wr_reg(CTL, 8'hFF);
      rd_chk(CTL, 8'h88, "ctl rw");
      wr_reg(OFS_OWN_ADDRESS, 8'hA5);
   endtask
   task automatic t_write();
      mst_u.start_cond();
      rd_chk(CTL, 8'h89, "after start");
      mst_u.send(8'hA4, a);
      chk("addr ack", {7'h0, a}, 8'h00);
      rd_chk(CTL, 8'hCA, "addr match");
      wr_reg(CTL, 8'h88);
      mst_u.send(8'h3C, a);
      chk("data ack", {7'h0, a}, 8'h00);
      rd_chk(OFS_DATA_BUFFER, 8'h3C, "rx byte");
      rd_chk(CTL, 8'hCA, "rx flag");
      wr_reg(CTL, 8'h80);
      mst_u.send(8'h11, a);
      chk("refused ack", {7'h0, a}, 8'h01);
      rd_chk(CTL, 8'hC0, "rx refused");
      mst_u.stop_cond();
   endtask
   task automatic t_mismatch();
      wr_reg(CTL, 8'h88);
      mst_u.start_cond();
      mst_u.send(8'hA6, a);
      chk("other addr", {7'h0, a}, 8'h01);
      mst_u.stop_cond();
      rd_chk(CTL, 8'h88, "other idle");
   endtask
   task automatic t_gc_read();
      mst_u.start_cond();
      mst_u.send(8'h00, a);
      chk("gc ack", {7'h0, a}, 8'h00);
      rd_chk(CTL, 8'hDA, "gc match");
      wr_reg(CTL, 8'h88);
      @(posedge clk);
      wr_reg(OFS_DATA_BUFFER, 8'h96);
      mst_u.start_cond();
      rd_chk(CTL, 8'hC9, "restart");
      mst_u.send(8'hA5, a);
      chk("read ack", {7'h0, a}, 8'h00);
      rd_chk(CTL, 8'hCB, "tx state");
      wr_reg(OFS_DATA_BUFFER, 8'h69);
      mst_u.fetch(1'b0, d);
      chk("tx byte 1", d, 8'h96);
      mst_u.fetch(1'b1, d);
      chk("tx byte 2", d, 8'h69);
      rd_chk(CTL, 8'hCC, "tx nack");
      mst_u.stop_cond();
      rd_chk(CTL, 8'hC8, "stop");
   endtask
   task automatic t_tx_abort();
      wr_reg(CTL, 8'h88);
      mst_u.start_cond();
      mst_u.send(8'hA5, a);
      wr_reg(CTL, 8'h80);
      mst_u.fetch(1'b0, d);
      chk("tx byte 3", d, 8'h69);
      rd_chk(CTL, 8'hC5, "tx aborted");
      mst_u.stop_cond();
   endtask
   task automatic t_off();
      sel <= 2'h1;
      wr_reg(CTL, 8'h88);
      mst_u.start_cond();
      mst_u.send(8'hA4, a);
      chk("other mode", {7'h0, a}, 8'h01);
      mst_u.stop_cond();
      sel <= PERSONALITY_TWO_WIRE;
      wr_reg(CTL, 8'h08);
      mst_u.start_cond();
      mst_u.send(8'hA4, a);
      chk("disabled", {7'h0, a}, 8'h01);
      mst_u.stop_cond();
   endtask

   // The whole sequence needs about 1550 cycles.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         error_cnt++;
         summarize();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_write();
      t_mismatch();
      t_gc_read();
      t_tx_abort();
      t_off();
      summarize();
   end
endmodule // tb

`default_nettype wire
